/* File: design/scx_consts.vh */
// Constants for the serial crosspoint control port
`ifndef SCX_CONSTS_VH
`define SCX_CONSTS_VH
`define SCX_WORD_BITS 16
`define SCX_AMP_COUNT 4
`define SCX_IN_BITS 3
`define SCX_FIELD_AMP_MSB 5
`define SCX_FIELD_AMP_LSB 4
`define SCX_FIELD_DIS 3
`define SCX_FIELD_IN_MSB 2
`define SCX_FIELD_IN_LSB 0
`define SCX_CFG_RESET 4'h8
`define SCX_CNT_W 5
// AXI register byte offsets
`define SCX_REG_CTRL 8'h00
`define SCX_REG_STATUS 8'h04
`define SCX_REG_SWITCH 8'h08
`define SCX_REG_INPUT 8'h0C
`define SCX_REG_LAST 8'h10
`define SCX_CTRL_PD_BIT 0
`define SCX_CTRL_RESET 32'h00000001
`define SCX_RESP_OKAY 2'h0
`define SCX_RESP_SLVERR 2'h2
`endif

/* File: design/scx_sync.v */
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module scx_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
    end
  end
  assign q = s2_ff;
endmodule // scx_sync

/* File: design/scx_ctrl.v */
// Serial crosspoint control port with AXI4-Lite register access
`timescale 1ns/100ps
`include "scx_consts.vh"

// Summary of operation
// RULE_01: Serial mode needs strobes high, select low.
// RULE_02: Configuration arrives in complete 16-bit words.
// RULE_03: Byte hosts send two bytes per word.
// RULE_04: Host keeps clock at 2 or 4 MHz; scx_host drives it at 8 MHz.
// RULE_05: Chain output lags input by sixteen clocks.
// RULE_06: Chain output changes on falling clock only.
// RULE_07: Chain output always driven, holds last bit.
// RULE_08: Chained devices share clock and select.
// RULE_09: Input registers stay writable in shutdown.
// RULE_10: Power-down control low leaves shutdown; here pd_reg_ff (CTRL bit 0, reset 1) must also be low.
// RULE_11: Power-on with strobes high disables amplifiers.
// RULE_12: Disabled or unprogrammed outputs are high impedance.
// RULE_13: Two-bit field picks output amplifier 0-3.
// RULE_14: Disable bit or three-bit input channel.
// RULE_15: Input bank and switch bank per amplifier.
// RULE_16: Sample input on rising clock, MSB first.
// RULE_17: Select rising edge loads addressed registers.
module scx_ctrl (
  input wire aclk,
  input wire aresetn,
  input wire sclk,
  input wire cs_n,
  input wire din,
  input wire wr_n,
  input wire update_n,
  input wire ce_n,
  input wire power_down_ctl,
  output reg dout,
  output reg dout_oe,
  output reg [11:0] amp_in_sel,
  output reg [3:0] amp_enable,
  output reg [3:0] amp_out_oe,
  output reg powered_down,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam WB = `SCX_WORD_BITS;
  localparam NA = `SCX_AMP_COUNT;

  // Pin inputs cross into aclk
  wire [6:0] pins_s;
  // Reset values match idle pins, so no false sclk edge after reset
  scx_sync #(.W(7), .INIT(7'h3C)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({power_down_ctl, ce_n, update_n, wr_n, cs_n, sclk, din}),
    .q(pins_s)
  );
  wire din_s = pins_s[0];
  wire sclk_s = pins_s[1];
  wire cs_s = pins_s[2];
  wire wr_s = pins_s[3];
  wire upd_s = pins_s[4];
  wire ce_s = pins_s[5];
  wire pd_s = pins_s[6];

  reg sclk_d_ff;
  reg cs_d_ff;
  reg [WB-1:0] shift_ff;
  reg [`SCX_CNT_W-1:0] cnt_ff;
  reg [4*NA-1:0] in_bank_ff;
  reg [4*NA-1:0] sw_bank_ff;
  reg [WB-1:0] last_word_ff;
  reg pd_reg_ff;
  reg [1:0] por_cnt_ff;
  reg por_dis_ff;

  // Serial mode qualifier
  wire par_idle = wr_s & upd_s & ce_s; // [RULE_01]
  wire serial_sel = par_idle & ~cs_s; // [RULE_01]
  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s & sclk_d_ff;
  wire cs_rise = cs_s & ~cs_d_ff;

  function [1:0] amp_of;
    input [WB-1:0] w;
    begin
      amp_of = w[`SCX_FIELD_AMP_MSB:`SCX_FIELD_AMP_LSB]; // [RULE_13]
    end
  endfunction

  wire [1:0] new_amp = amp_of(shift_ff);
  wire [3:0] new_cfg = shift_ff[`SCX_FIELD_DIS:`SCX_FIELD_IN_LSB];
  // Frames under 16 bits are dropped; longer frames load their last 16 bits
  wire word_ok = (cnt_ff >= WB[`SCX_CNT_W-1:0]); // [RULE_02]

  always @(posedge aclk) begin
    if (!aresetn) begin
      sclk_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
      shift_ff <= {WB{1'b0}};
      cnt_ff <= {`SCX_CNT_W{1'b0}};
      in_bank_ff <= {NA{`SCX_CFG_RESET}};
      sw_bank_ff <= {NA{`SCX_CFG_RESET}};
      last_word_ff <= {WB{1'b0}};
      dout <= 1'b0;
      dout_oe <= 1'b1;
      por_cnt_ff <= 2'h0;
      por_dis_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_d_ff <= cs_s;
      dout_oe <= 1'b1; // [RULE_07]
      // Strap caught once the synchroniser holds real pin values
      if (por_cnt_ff != 2'h3)
        por_cnt_ff <= por_cnt_ff + 2'h1;
      if (por_cnt_ff == 2'h2)
        por_dis_ff <= upd_s & cs_s; // [RULE_11]
      if (serial_sel && sclk_rise) begin
        shift_ff <= {shift_ff[WB-2:0], din_s}; // [RULE_16]
        if (cnt_ff != 5'h1F)
          cnt_ff <= cnt_ff + 5'h01;
      end
      // Bit 15 leaves the register; 16 clocks late, on falling edge
      if (serial_sel && sclk_fall)
        dout <= shift_ff[WB-1]; // [RULE_05] [RULE_06]
      if (cs_rise && par_idle) begin
        cnt_ff <= {`SCX_CNT_W{1'b0}};
        if (word_ok) begin
          // Writable even while powered down
          in_bank_ff[4*new_amp +: 4] <= new_cfg; // [RULE_09] [RULE_15] [RULE_17]
          sw_bank_ff[4*new_amp +: 4] <= new_cfg; // [RULE_15] [RULE_17]
          last_word_ff <= shift_ff;
        end
      end else if (!serial_sel && cs_s) begin
        cnt_ff <= {`SCX_CNT_W{1'b0}};
      end
    end
  end

  // Amplifier outputs
  wire pd_eff = pd_s | pd_reg_ff;
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      amp_in_sel <= 12'h000;
      amp_enable <= 4'h0;
      amp_out_oe <= 4'h0;
      powered_down <= 1'b1;
    end else begin
      powered_down <= pd_eff; // [RULE_10]
      for (i = 0; i < NA; i = i + 1) begin
        amp_in_sel[3*i +: 3] <= sw_bank_ff[4*i +: 3]; // [RULE_14]
        // Disabled amp or powered down floats the output
        amp_enable[i] <= ~sw_bank_ff[4*i+3] & ~pd_eff; // [RULE_14] [RULE_10]
        amp_out_oe[i] <= ~sw_bank_ff[4*i+3] & ~pd_eff; // [RULE_12]
      end
    end
  end

  // AXI4-Lite slave
  reg aw_got_ff;
  reg w_got_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_got_ff | aw_hs;
  wire w_have = w_got_ff | w_hs;
  wire [7:0] wa = aw_got_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wd = w_got_ff ? wdata_ff : s_axi_wdata;
  wire [3:0] ws = w_got_ff ? wstrb_ff : s_axi_wstrb;
  wire do_write = aw_have & w_have & ~s_axi_bvalid;

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `SCX_REG_CTRL) || (a == `SCX_REG_STATUS) ||
               (a == `SCX_REG_SWITCH) || (a == `SCX_REG_INPUT) ||
               (a == `SCX_REG_LAST);
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCX_RESP_OKAY;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      pd_reg_ff <= 1'b1;
    end else begin
      s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~s_axi_awready;
      s_axi_wready <= ~w_have & ~s_axi_bvalid & ~s_axi_wready;
      if (aw_hs) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wa) ? `SCX_RESP_OKAY : `SCX_RESP_SLVERR;
        if (wa == `SCX_REG_CTRL && ws[0])
          pd_reg_ff <= wd[`SCX_CTRL_PD_BIT]; // [RULE_10]
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SCX_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? `SCX_RESP_OKAY : `SCX_RESP_SLVERR;
        case (s_axi_araddr)
          `SCX_REG_CTRL: s_axi_rdata <= {31'h0, pd_reg_ff};
          `SCX_REG_STATUS: s_axi_rdata <= {26'h0, por_dis_ff, powered_down,
                                           amp_enable};
          `SCX_REG_SWITCH: s_axi_rdata <= {16'h0, sw_bank_ff};
          `SCX_REG_INPUT: s_axi_rdata <= {16'h0, in_bank_ff};
          `SCX_REG_LAST: s_axi_rdata <= {16'h0, last_word_ff};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // scx_ctrl

/* File: verif/scx_ctrl_sva.sv */
// Port checker for the serial crosspoint control port
`timescale 1ns/100ps
module scx_chk (
  input logic aclk,
  input logic aresetn,
  input logic sclk,
  input logic cs_n,
  input logic wr_n,
  input logic update_n,
  input logic ce_n,
  input logic power_down_ctl,
  input logic dout,
  input logic dout_oe,
  input logic [11:0] amp_in_sel,
  input logic [3:0] amp_enable,
  input logic [3:0] amp_out_oe,
  input logic powered_down
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chain_drive_a: assert property (dout_oe) else $error("chain out undriven");
  idle_hold_a: assert property (cs_n [*8] |=> $stable(dout)) else $error("dout moved");
  fall_only_a: assert property ($changed(dout) |-> !sclk) else $error("dout off fall");
  off_is_hiz_a: assert property ((amp_out_oe & ~amp_enable) == 4'h0 && (!powered_down || amp_out_oe == 4'h0))
    else $error("oe on disabled amp");
  strobe_gate_a: assert property ((!wr_n || !update_n || !ce_n) [*8] |=> $stable(amp_in_sel))
    else $error("load with strobe low");
  load_on_rise_a: assert property ($changed(amp_in_sel) |-> cs_n)
    else $error("load inside frame");
  pd_enter_a: assert property (power_down_ctl [*4] |=> powered_down)
    else $error("pin shutdown missed");
  pd_leave_a: assert property ($fell(powered_down) |-> $past(power_down_ctl, 2) == 1'b0)
    else $error("left shutdown with pin high");
  // Reset itself is the cause here, so no disable
  reset_off_a: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> amp_enable == 4'h0 && amp_out_oe == 4'h0 && powered_down)
    else $error("amps live after reset");
  cover property ($changed(dout));
  cover property ($rose(amp_enable[3]));
  cover property ($fell(powered_down));
endmodule // scx_chk

bind scx_ctrl scx_chk u_chk (.aclk(aclk), .aresetn(aresetn), .sclk(sclk), .cs_n(cs_n),
  .wr_n(wr_n), .update_n(update_n), .ce_n(ce_n), .power_down_ctl(power_down_ctl),
  .dout(dout), .dout_oe(dout_oe), .amp_in_sel(amp_in_sel), .amp_enable(amp_enable),
  .amp_out_oe(amp_out_oe), .powered_down(powered_down));

/* File: verif/scx_host.sv */
// Serial host model driving clock, select and data
`timescale 1ns/100ps
module scx_host (
  output logic sclk,
  output logic cs_n,
  output logic din
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // Sends data[n-1:0] in one frame; two bytes or one word alike
  task automatic send(input logic [31:0] data, input int n);
    cs_n = 1'b0;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      din = data[i];
      #62.5;
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
    #100;
    cs_n = 1'b1;
    din = ~din; // Released line is not held
    #400;
  endtask
endmodule // scx_host

/* File: verif/test_serial_crosspoint_control.sv */
// Self-checking bench for the serial crosspoint control port
`timescale 1ns/100ps
`include "scx_consts.vh"
module test_serial_crosspoint_control;
  logic aclk, aresetn, wr_n, update_n, ce_n, power_down_ctl, dout, dout_oe, powered_down;
  logic sclk, cs_n, din, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] amp_in_sel;
  logic [3:0] amp_enable, amp_out_oe, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int bad_count = 0;
  int compares = 0;
  // Word, then {2'b0, amp, enabled, input}
  logic [23:0] rows [0:8] = '{24'hAB0008, 24'h001119, 24'hFF222A, 24'h00333B, 24'h54040C,
    24'h00151D, 24'h00262E, 24'h80373F, 24'h002820};
  scx_host host (.sclk(sclk), .cs_n(cs_n), .din(din));
  scx_ctrl dut (.aclk(aclk), .aresetn(aresetn), .sclk(sclk), .cs_n(cs_n), .din(din),
    .wr_n(wr_n), .update_n(update_n), .ce_n(ce_n), .power_down_ctl(power_down_ctl),
    .dout(dout), .dout_oe(dout_oe), .amp_in_sel(amp_in_sel), .amp_enable(amp_enable),
    .amp_out_oe(amp_out_oe), .powered_down(powered_down), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int t = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && ++t < 50);
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int t = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && ++t < 50);
    chk(s_axi_rvalid, 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    #300000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    {aresetn, wr_n, update_n, ce_n, power_down_ctl} = 5'h0F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0, 4'hF};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axr(`SCX_REG_STATUS, d, rr);
    chk(d[5:0], 6'h30);
    host.send(32'h0035, 16);
    axr(`SCX_REG_INPUT, d, rr);
    chk(d[15:12], 4'h5);
    @(posedge aclk);
    power_down_ctl <= 1'b0;
    axw(`SCX_REG_CTRL, 32'h0, `SCX_RESP_OKAY);
    axw(8'h44, 32'h1, `SCX_RESP_SLVERR);
    axr(`SCX_REG_STATUS, d, rr);
    chk(d[4], 1'b0);
    chk({amp_enable[3], amp_in_sel[11:9]}, 4'hD);
    axr(8'h40, d, rr);
    chk(rr, `SCX_RESP_SLVERR);
    chk(d, 32'h0);
    for (int r = 0; r < 9; r++) begin
      host.send(rows[r][23:8], 16);
      chk(amp_enable[rows[r][5:4]], rows[r][3]);
      if (rows[r][3]) chk(amp_in_sel[rows[r][5:4] * 3 +: 3], rows[r][2:0]);
    end
    host.send(32'h16, 8);
    chk(amp_in_sel[5:3], 3'h5);
    host.send({16'h0000, 16'h8002}, 32);
    chk(dout, 1'b1);
    chk(amp_in_sel[2:0], 3'h2);
    @(posedge aclk);
    wr_n <= 1'b0;
    host.send(32'h0007, 16);
    chk(amp_in_sel[2:0], 3'h2);
    report_and_stop();
  end
endmodule // test_serial_crosspoint_control
